// *** verilog/counter_pkg.sv ***
/*
  Constants, types and register map of the counting channel.
  Assumes a 50 MHz APB clock.
*/
package counter_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int DIR_STABLE_NS = 3000;
  localparam int DIR_STABLE_CYCLES = (DIR_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PINS_SETTLE_CYCLES = 3;

  // ----------------------------------------------------------------
  // Widths and identity
  // ----------------------------------------------------------------
  localparam int COUNT_WIDTH = 25;
  localparam int CHANNELS_SMALL = 2;
  localparam int CHANNELS_LARGE = 4;
  localparam logic [7:0] BLOCK_ID = 8'h5A;  // Arbitrary value

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_THRESH0 = 8'h08;
  localparam logic [7:0] OFS_THRESH1 = 8'h0C;
  localparam logic [7:0] OFS_CURRENT = 8'h10;
  localparam logic [7:0] OFS_CAPTURE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IDENT = 8'h1C;

  // ----------------------------------------------------------------
  // Status bit positions (bits 0 to 2 are sticky, write one to clear)
  // ----------------------------------------------------------------
  localparam int ST_THR0_CROSS = 0;
  localparam int ST_THR1_CROSS = 1;
  localparam int ST_SUPPLY_FAULT = 2;
  localparam int ST_SUPPLY_LIVE = 3;
  localparam int ST_CMP0 = 4;
  localparam int ST_CMP1 = 5;
  localparam int ST_DOWN = 6;
  localparam int ST_OUT_ZERO = 7;
  localparam int ST_OUT_ONE = 8;
  localparam int ST_CAM_ARMED = 9;
  localparam int STATUS_USED = 10;
  localparam int CTRL_USED = 14;

  // ----------------------------------------------------------------
  // Modes and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SEPARATE = 2'b00,
    MODE_PULSE_DIR = 2'b01,
    MODE_SW_DIR = 2'b10,
    MODE_QUAD = 2'b11
  } count_mode_t;

  typedef enum logic [2:0] {
    PRE_NONE = 3'b000,
    PRE_ANY_EDGE = 3'b001,
    PRE_DIR_MATCHED = 3'b010,
    PRE_DIR_OPPOSED = 3'b011,
    PRE_LEVEL = 3'b100,
    PRE_SHORT_CAM = 3'b101,
    PRE_LONG_CAM = 3'b110
  } preset_mode_t;

  // Control word, bit 0 at the bottom
  typedef struct packed {
    logic manual_out_one;
    logic manual_out_zero;
    logic out_one_en;
    logic out_zero_en;
    logic out_manual;
    logic sw_enable;
    logic preset_confirm;
    preset_mode_t preset_mode;
    logic sw_down;
    logic quad_x4;
    count_mode_t count_mode;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '0;

  // Pin group seen by the counting logic
  typedef struct packed {
    logic a;
    logic b;
    logic z;
    logic pres;
    logic val;
    logic capt;
    logic supply;
  } pins_t;

  // Supply return idles high so reset shows no fault
  localparam pins_t PINS_RESET = 7'h01;

endpackage

// *** verilog/up_down_counter_channel.sv ***
/*
  One up/down counting channel with an APB register slave, preset logic,
  threshold events, capture, supply check and two reflex outputs.
  Assumes pins synchronous to pclk and an APB master; a module of two
  or four channels holds one instance per channel.
*/
`timescale 1ns/1ns

module up_down_counter_channel
  import counter_pkg::*;
#(
  parameter int CNT_W = COUNT_WIDTH,
  parameter int CHANNEL_INDEX = 0,
  parameter int CHANNELS = CHANNELS_SMALL
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_input_a,
  input wire logic count_input_b,
  input wire logic top_turn_input,
  input wire logic preset_input,
  input wire logic count_enable_input,
  input wire logic capture_input,
  input wire logic encoder_supply_return,
  output logic reflex_output_zero,
  output logic reflex_output_one
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic rise(input logic now, input logic was);
    return now & ~was;
  endfunction

  function automatic logic fall(input logic now, input logic was);
    return ~now & was;
  endfunction

  function automatic logic at_or_above(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] t);
    return v >= t;
  endfunction

  function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
    return 32'(v);
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_IDENT);
  endfunction

  localparam logic [7:0] DIR_LIMIT = 8'(DIR_STABLE_CYCLES);
  localparam logic [1:0] SETTLE_LIMIT = 2'(PINS_SETTLE_CYCLES);
  localparam logic [7:0] CHANNEL_ID = 8'(CHANNEL_INDEX);
  localparam logic [7:0] CHANNEL_NUM = 8'(CHANNELS);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  ctrl_t ctrl;
  logic [CNT_W-1:0] preset_value, thresh0, thresh1, current, captured;
  logic thr0_cross, thr1_cross, supply_fault, count_down, cam_armed, wr_access;
  logic [31:0] status_word;

  assign wr_access = psel & penable & pwrite;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pins_t pins_meta, pins_now, pins_was, pins_raw;
  logic [1:0] settle_cnt;
  logic pins_ready;

  assign pins_raw = {count_input_a, count_input_b, top_turn_input, preset_input,
                     count_enable_input, capture_input, encoder_supply_return};

  // Two stages, then one more for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta <= PINS_RESET;
      pins_now <= PINS_RESET;
      pins_was <= PINS_RESET;
    end else begin
      pins_meta <= pins_raw;
      pins_now <= pins_meta;
      pins_was <= pins_now;
    end
  end

  // Blocks false edges until the pipeline holds real pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= '0;
    end else if (settle_cnt != SETTLE_LIMIT) begin
      settle_cnt <= settle_cnt + 2'd1;
    end
  end

  assign pins_ready = (settle_cnt == SETTLE_LIMIT);

  // ----------------------------------------------------------------
  // Direction input stability window
  // ----------------------------------------------------------------
  logic [7:0] dir_stable_cnt;
  logic dir_stable;

  // Restarts on every change of b, saturates at the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_stable_cnt <= '0;
    end else if (pins_now.b != pins_was.b) begin
      dir_stable_cnt <= '0;
    end else if (dir_stable_cnt != DIR_LIMIT) begin
      dir_stable_cnt <= dir_stable_cnt + 8'd1;
    end
  end

  assign dir_stable = (dir_stable_cnt == DIR_LIMIT);

  // ----------------------------------------------------------------
  // Count event decoding
  // ----------------------------------------------------------------
  logic up_ev, dn_ev, counting, next_down;

  assign counting = (pins_now.val | ctrl.sw_enable) & pins_ready;

  // Exactly one counting mode decodes the pins
  always_comb begin
    up_ev = 1'b0;
    dn_ev = 1'b0;
    unique case (ctrl.count_mode)
      MODE_SEPARATE: begin
        up_ev = rise(pins_now.a, pins_was.a);
        dn_ev = rise(pins_now.b, pins_was.b);
      end
      MODE_PULSE_DIR: begin
        if (rise(pins_now.a, pins_was.a) && dir_stable) begin
          up_ev = ~pins_now.b;
          dn_ev = pins_now.b;
        end
      end
      MODE_SW_DIR: begin
        up_ev = rise(pins_now.a, pins_was.a) & ~ctrl.sw_down;
        dn_ev = rise(pins_now.a, pins_was.a) & ctrl.sw_down;
      end
      MODE_QUAD: begin
        if (ctrl.quad_x4) begin
          // Any edge of either track; track a leading counts up
          if ((pins_now.a != pins_was.a) || (pins_now.b != pins_was.b)) begin
            up_ev = pins_now.a ^ pins_was.b;
            dn_ev = ~(pins_now.a ^ pins_was.b);
          end
        end else if (rise(pins_now.b, pins_was.b)) begin
          up_ev = pins_now.a;
          dn_ev = ~pins_now.a;
        end
      end
    endcase
    up_ev = up_ev & counting;
    dn_ev = dn_ev & counting;
  end

  // Direction follows its source in level modes, else the last step
  always_comb begin
    next_down = count_down;
    if (ctrl.count_mode == MODE_SW_DIR) begin
      next_down = ctrl.sw_down;
    end else if (ctrl.count_mode == MODE_PULSE_DIR && dir_stable) begin
      next_down = pins_now.b;
    end else if (up_ev != dn_ev) begin
      next_down = dn_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_down <= 1'b0;
    end else begin
      count_down <= next_down;
    end
  end

  // ----------------------------------------------------------------
  // Preset triggers
  // ----------------------------------------------------------------
  logic preset_hit, trig, pres_rise, pres_fall, z_rise, z_fall;

  assign pres_rise = rise(pins_now.pres, pins_was.pres);
  assign pres_fall = fall(pins_now.pres, pins_was.pres);
  assign z_rise = rise(pins_now.z, pins_was.z);
  assign z_fall = fall(pins_now.z, pins_was.z);

  // One preset mode selects the trigger
  always_comb begin
    trig = 1'b0;
    unique case (ctrl.preset_mode)
      PRE_NONE: trig = 1'b0;
      PRE_ANY_EDGE: trig = pres_rise | pres_fall;
      PRE_DIR_MATCHED: trig = count_down ? pres_fall : pres_rise;
      PRE_DIR_OPPOSED: trig = count_down ? pres_rise : pres_fall;
      PRE_LEVEL: trig = pins_now.pres;
      // Each active top turn inside the cam reloads
      PRE_SHORT_CAM: trig = pins_now.pres & (count_down ? z_fall : z_rise);
      PRE_LONG_CAM: trig = cam_armed & z_rise;
      default: trig = 1'b0;
    endcase
  end

  // Without confirmation no pin trigger takes effect
  assign preset_hit = trig & ctrl.preset_confirm & pins_ready;

  // Long cam arms when the cam input is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cam_armed <= 1'b0;
    end else if (ctrl.preset_mode != PRE_LONG_CAM || pins_now.pres) begin
      cam_armed <= 1'b0;
    end else if (pres_fall) begin
      cam_armed <= 1'b1;
    end else if (preset_hit) begin
      cam_armed <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Current value and capture
  // ----------------------------------------------------------------
  // Preset beats counting; both inputs at once cancel out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current <= '0;
    end else if (preset_hit) begin
      current <= preset_value;
    end else if (up_ev && !dn_ev) begin
      current <= current + 1'b1;
    end else if (dn_ev && !up_ev) begin
      current <= current - 1'b1;
    end
  end

  // Rising edge of the capture pin latches the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured <= '0;
    end else if (pins_ready && rise(pins_now.capt, pins_was.capt)) begin
      captured <= current;
    end
  end

  // ----------------------------------------------------------------
  // Thresholds and supply check
  // ----------------------------------------------------------------
  logic cmp0, cmp1, cmp0_was, cmp1_was, clr_write;

  assign cmp0 = at_or_above(current, thresh0);
  assign cmp1 = at_or_above(current, thresh1);
  assign clr_write = wr_access && (paddr == OFS_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp0_was <= 1'b0;
      cmp1_was <= 1'b0;
    end else begin
      cmp0_was <= cmp0;
      cmp1_was <= cmp1;
    end
  end

  // Sticky flags; a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr0_cross <= 1'b0;
      thr1_cross <= 1'b0;
      supply_fault <= 1'b0;
    end else begin
      thr0_cross <= (thr0_cross & ~(clr_write & pwdata[ST_THR0_CROSS])) |
                    (cmp0 != cmp0_was);
      thr1_cross <= (thr1_cross & ~(clr_write & pwdata[ST_THR1_CROSS])) |
                    (cmp1 != cmp1_was);
      supply_fault <= (supply_fault & ~(clr_write & pwdata[ST_SUPPLY_FAULT])) |
                      ~pins_now.supply;
    end
  end

  // ----------------------------------------------------------------
  // Reflex outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reflex_output_zero <= 1'b0;
      reflex_output_one <= 1'b0;
    end else if (ctrl.out_manual) begin
      reflex_output_zero <= ctrl.manual_out_zero;
      reflex_output_one <= ctrl.manual_out_one;
    end else begin
      reflex_output_zero <= cmp0 & ctrl.out_zero_en;
      reflex_output_one <= cmp1 & ctrl.out_one_en;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_comb begin
    status_word = '0;
    status_word[ST_THR0_CROSS] = thr0_cross;
    status_word[ST_THR1_CROSS] = thr1_cross;
    status_word[ST_SUPPLY_FAULT] = supply_fault;
    status_word[ST_SUPPLY_LIVE] = ~pins_now.supply;
    status_word[ST_CMP0] = cmp0;
    status_word[ST_CMP1] = cmp1;
    status_word[ST_DOWN] = count_down;
    status_word[ST_OUT_ZERO] = reflex_output_zero;
    status_word[ST_OUT_ONE] = reflex_output_one;
    status_word[ST_CAM_ARMED] = cam_armed;
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);

  // Configuration writes take effect in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      preset_value <= '0;
      thresh0 <= '0;
      thresh1 <= '0;
    end else if (wr_access) begin
      unique case (paddr)
        OFS_CTRL: ctrl <= ctrl_t'(pwdata[CTRL_USED-1:0]);
        OFS_PRESET: preset_value <= pwdata[CNT_W-1:0];
        OFS_THRESH0: thresh0 <= pwdata[CNT_W-1:0];
        OFS_THRESH1: thresh1 <= pwdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data is sampled in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OFS_CTRL: prdata <= {{(32 - CTRL_USED){1'b0}}, ctrl};
        OFS_PRESET: prdata <= widen(preset_value);
        OFS_THRESH0: prdata <= widen(thresh0);
        OFS_THRESH1: prdata <= widen(thresh1);
        OFS_CURRENT: prdata <= widen(current);
        OFS_CAPTURE: prdata <= widen(captured);
        OFS_STATUS: prdata <= status_word;
        OFS_IDENT: prdata <= {8'h00, BLOCK_ID, CHANNEL_NUM, CHANNEL_ID};
        default: prdata <= '0;
      endcase
    end
  end

endmodule

// *** sim/up_down_counter_channel_sva.sv ***
/* Checks on the APB slave and reflex outputs.
   Sees only the channel's ports. */
`timescale 1ns/1ns

module up_down_counter_channel_sva
  import counter_pkg::*;
#(
  parameter int CHANNEL_INDEX = 0,
  parameter int CHANNELS = CHANNELS_SMALL
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reflex_output_zero,
  input wire logic reflex_output_one
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ctrl_t ctrl_q;
  logic [31:0] thr0_q;
  logic [2:0] age;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_IDENT);
  // Write shadows and cycles since the last write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      thr0_q <= '0;
      age <= '0;
    end else begin
      if (wr_acc && paddr == OFS_CTRL) ctrl_q <= ctrl_t'(pwdata[CTRL_USED-1:0]);
      if (wr_acc && paddr == OFS_THRESH0) thr0_q <= pwdata;
      if (wr_acc) age <= '0;
      else if (age != 3'd7) age <= age + 3'd1;
    end
  end
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; pslverr == (psel && penable && !mapped); endproperty
  a_err: assert property (p_err) else $error("pslverr wrong for address");
  property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("prdata moved outside read setup");
  property p_unmapped; rd_acc && !mapped |-> prdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ident;
    rd_acc && paddr == OFS_IDENT |-> prdata == {8'h00, BLOCK_ID, 8'(CHANNELS), 8'(CHANNEL_INDEX)};
  endproperty
  a_ident: assert property (p_ident) else $error("ident word wrong");
  property p_ctrl; rd_acc && paddr == OFS_CTRL |-> prdata == {18'h0, ctrl_q}; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  property p_manual;
    age >= 3'd4 && ctrl_q.out_manual |-> reflex_output_zero == ctrl_q.manual_out_zero
      && reflex_output_one == ctrl_q.manual_out_one;
  endproperty
  a_manual: assert property (p_manual) else $error("manual level not driven");
  property p_man_rise; wr_acc && paddr == OFS_CTRL && pwdata[9] && pwdata[12]
    |-> ##[1:3] reflex_output_zero; endproperty
  a_man_rise: assert property (p_man_rise) else $error("manual high late");
  property p_off;
    age >= 3'd4 && !ctrl_q.out_manual |-> (ctrl_q.out_zero_en || !reflex_output_zero)
      && (ctrl_q.out_one_en || !reflex_output_one);
  endproperty
  a_off: assert property (p_off) else $error("disabled output not low");
  property p_copy; age >= 3'd4 && !ctrl_q.out_manual && ctrl_q.out_zero_en
    && thr0_q == 32'h0000_0000 |-> reflex_output_zero; endproperty
  a_copy: assert property (p_copy) else $error("counter output not copied");
endmodule

// *** sim/pulse_source_model.sv ***
/* Pulse sensor or encoder with auxiliary inputs.
   Assumes a caller that runs its tasks. */
`timescale 1ns/1ns

module pulse_source_model
  import counter_pkg::*;
(
  input wire logic pclk,
  output pins_t pins
);
  // Idle pattern: all low, supply return high
  initial pins = PINS_RESET;
  // One pin pattern launched after a rising edge and held
  task automatic drive(input pins_t p, input int hold);
    @(posedge pclk);
    pins <= p;
    repeat (hold - 1) @(posedge pclk);
  endtask
  // Whole pulses on the masked pins, three cycles high and low
  task automatic pulse(input pins_t m, input int n);
    for (int i = 0; i < n; i++) begin
      drive(pins | m, 3);
      drive(pins & ~m, 3);
    end
  endtask
  // Two tracks a quarter period apart; forward has track a leading
  task automatic quad(input int periods, input logic fwd);
    pins_t p;
    logic [1:0] k;
    for (int i = 0; i < 4 * periods; i++) begin
      k = 2'((i + 1) % 4);
      p = pins;
      p.a = fwd ? k[0] ^ k[1] : k[1];
      p.b = fwd ? k[1] : k[0] ^ k[1];
      drive(p, 3);
    end
  endtask
endmodule

// *** sim/up_down_counter_channel_tb.sv ***
/* Self-checking bench: APB tasks and a pulse source.
   Assumes the package, channel, checker and source. */
`timescale 1ns/1ns

module up_down_counter_channel_tb
  import counter_pkg::*;
;
  typedef struct packed {preset_mode_t m; logic dn; logic rise; logic conf; logic hit;} pcase_t;
  localparam pins_t PA = 7'h40, PB = 7'h20, PZ = 7'h10, PP = 7'h08;
  localparam pins_t PV = 7'h04, PC = 7'h02, PS = 7'h01;
  localparam pcase_t PCASES [11] = '{
    '{PRE_ANY_EDGE, 0, 1, 1, 1}, '{PRE_ANY_EDGE, 0, 0, 1, 1}, '{PRE_ANY_EDGE, 1, 1, 1, 1},
    '{PRE_ANY_EDGE, 0, 1, 0, 0}, '{PRE_DIR_MATCHED, 0, 1, 1, 1}, '{PRE_DIR_MATCHED, 0, 0, 1, 0},
    '{PRE_DIR_MATCHED, 1, 0, 1, 1}, '{PRE_DIR_MATCHED, 1, 1, 1, 0},
    '{PRE_DIR_OPPOSED, 0, 0, 1, 1}, '{PRE_DIR_OPPOSED, 0, 1, 1, 0}, '{PRE_DIR_OPPOSED, 1, 1, 1, 1}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, v, base;
  logic pready, pslverr, reflex_output_zero, reflex_output_one, err;
  pins_t pins;
  ctrl_t c;
  int mismatches = 0;
  int compares = 0;

  initial forever #10 pclk = ~pclk;
  up_down_counter_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_input_a(pins.a), .count_input_b(pins.b), .top_turn_input(pins.z),
    .preset_input(pins.pres), .count_enable_input(pins.val), .capture_input(pins.capt),
    .encoder_supply_return(pins.supply), .reflex_output_zero(reflex_output_zero),
    .reflex_output_one(reflex_output_one));
  pulse_source_model enc (.pclk(pclk), .pins(pins));

  // ----------------------------------------------------------------
  // Comparison, APB master and verdict
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic se);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, v, err);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    repeat (4) @(posedge pclk);
    apb(1'b0, a, 32'h0000_0000, q, err);
  endtask
  task automatic chk_cur(input logic [31:0] exp);
    rd(OFS_CURRENT, v);
    check(v, exp);
  endtask
  task automatic chk_st(input logic [31:0] m, input logic [31:0] exp);
    rd(OFS_STATUS, v);
    check(v & m, exp);
  endtask
  task automatic wctrl;
    wr(OFS_CTRL, {18'h0, c});
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    c = CTRL_RESET;
    c.sw_enable = 1'b1;
    wctrl();
    enc.pulse(PA, 3);
    enc.pulse(PB, 1);
    chk_cur(32'h0000_0002);
    enc.pulse(PA | PB, 2);
    enc.drive(pins | PA, 3);
    enc.drive(pins | PB, 3);
    enc.drive(pins & ~PA, 3);
    enc.drive(pins & ~PB, 3);
    chk_cur(32'h0000_0002);
    c.sw_enable = 1'b0;
    wctrl();
    enc.pulse(PA, 2);
    chk_cur(32'h0000_0002);
    enc.drive(pins | PV, 3);
    enc.pulse(PA, 1);
    chk_cur(32'h0000_0003);
    enc.drive(pins & ~PV, 3);
    c.sw_enable = 1'b1;
    c.count_mode = MODE_PULSE_DIR;
    wctrl();
    enc.drive(pins, DIR_STABLE_CYCLES + 10);
    enc.pulse(PA, 2);
    chk_cur(32'h0000_0005);
    enc.drive(pins | PB, DIR_STABLE_CYCLES + 10);
    enc.pulse(PA, 1);
    chk_cur(32'h0000_0004);
    enc.drive(pins & ~PB, 10);
    enc.pulse(PA, 1);
    chk_cur(32'h0000_0004);
    c.count_mode = MODE_SW_DIR;
    c.sw_down = 1'b1;
    wctrl();
    enc.pulse(PA, 2);
    chk_cur(32'h0000_0002);
    c.sw_down = 1'b0;
    wctrl();
    enc.pulse(PA, 1);
    chk_cur(32'h0000_0003);
    c.count_mode = MODE_QUAD;
    wctrl();
    enc.quad(2, 1'b1);
    chk_cur(32'h0000_0005);
    enc.quad(1, 1'b0);
    chk_cur(32'h0000_0004);
    c.quad_x4 = 1'b1;
    wctrl();
    enc.quad(1, 1'b1);
    chk_cur(32'h0000_0008);
    enc.quad(2, 1'b0);
    chk_cur(32'h0000_0000);
    done("counting");
    c.quad_x4 = 1'b0;
    c.count_mode = MODE_SW_DIR;
    wr(OFS_PRESET, 32'h0000_0100);
    foreach (PCASES[i]) begin
      c.preset_mode = PCASES[i].m;
      c.sw_down = PCASES[i].dn;
      c.preset_confirm = 1'b0;
      wctrl();
      enc.drive(PCASES[i].rise ? (pins & ~PP) : (pins | PP), 3);
      enc.pulse(PA, 2);
      rd(OFS_CURRENT, base);
      c.preset_confirm = PCASES[i].conf;
      wctrl();
      enc.drive(PCASES[i].rise ? (pins | PP) : (pins & ~PP), 3);
      chk_cur(PCASES[i].hit ? 32'h0000_0100 : base);
    end
    c.preset_mode = PRE_LEVEL;
    c.sw_down = 1'b0;
    c.preset_confirm = 1'b1;
    wctrl();
    enc.drive(pins | PP, 3);
    enc.pulse(PA, 2);
    chk_cur(32'h0000_0100);
    enc.drive(pins & ~PP, 3);
    enc.pulse(PA, 1);
    chk_cur(32'h0000_0101);
    c.preset_mode = PRE_SHORT_CAM;
    wctrl();
    enc.drive(pins | PP, 3);
    enc.pulse(PA, 2);
    enc.drive(pins | PZ, 3);
    chk_cur(32'h0000_0100);
    enc.pulse(PA, 2);
    enc.drive(pins & ~PZ, 3);
    chk_cur(32'h0000_0102);
    enc.drive(pins | PZ, 3);
    chk_cur(32'h0000_0100);
    c.sw_down = 1'b1;
    wctrl();
    enc.pulse(PA, 2);
    chk_cur(32'h0000_00FE);
    enc.drive(pins & ~PZ, 3);
    chk_cur(32'h0000_0100);
    c.preset_mode = PRE_LONG_CAM;
    c.sw_down = 1'b0;
    wctrl();
    enc.drive(pins & ~PP, 3);
    enc.pulse(PA, 2);
    enc.drive(pins | PZ, 3);
    chk_cur(32'h0000_0100);
    enc.drive(pins & ~PZ, 3);
    enc.pulse(PA, 2);
    enc.drive(pins | PZ, 3);
    chk_cur(32'h0000_0102);
    enc.drive(pins & ~PZ, 3);
    done("preset");
    c = CTRL_RESET;
    c.out_zero_en = 1'b1;
    wctrl();
    rd(OFS_CTRL, v);
    check(v, {18'h0, c});
    check(reflex_output_zero, 1'b1);
    check(reflex_output_one, 1'b0);
    c.out_manual = 1'b1;
    c.manual_out_one = 1'b1;
    wctrl();
    rd(OFS_STATUS, v);
    check({reflex_output_one, reflex_output_zero}, 2'b10);
    c.manual_out_one = 1'b0;
    c.manual_out_zero = 1'b1;
    wctrl();
    rd(OFS_STATUS, v);
    check({reflex_output_one, reflex_output_zero}, 2'b01);
    done("outputs");
    rd(OFS_CURRENT, base);
    wr(OFS_THRESH0, base + 32'h0000_0001);
    wr(OFS_THRESH1, base + 32'h0000_0001);
    c = CTRL_RESET;
    c.sw_enable = 1'b1;
    wctrl();
    wr(OFS_STATUS, 32'h0000_0007);
    chk_st(32'h0000_0033, 32'h0000_0000);
    enc.pulse(PA, 1);
    chk_st(32'h0000_0033, 32'h0000_0033);
    wr(OFS_STATUS, 32'h0000_0003);
    chk_st(32'h0000_0033, 32'h0000_0030);
    enc.drive(pins & ~PS, 3);
    chk_st(32'h0000_000C, 32'h0000_000C);
    enc.drive(pins | PS, 3);
    chk_st(32'h0000_000C, 32'h0000_0004);
    wr(OFS_STATUS, 32'h0000_0004);
    chk_st(32'h0000_000C, 32'h0000_0000);
    rd(OFS_CURRENT, base);
    enc.pulse(PC, 1);
    enc.pulse(PA, 2);
    rd(OFS_CAPTURE, v);
    check(v, base);
    wr(OFS_CURRENT, 32'h0000_0055);
    chk_cur(base + 32'h0000_0002);
    apb(1'b0, 8'h20, 32'h0000_0000, v, err);
    check(err, 1'b1);
    check(v, 32'h0000_0000);
    rd(OFS_IDENT, v);
    check(v, {8'h00, BLOCK_ID, 8'h02, 8'h00});
    done("registers");
    give_verdict();
  end
endmodule

bind up_down_counter_channel up_down_counter_channel_sva #(
  .CHANNEL_INDEX(CHANNEL_INDEX), .CHANNELS(CHANNELS)
) chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reflex_output_zero(reflex_output_zero), .reflex_output_one(reflex_output_one));
